// ### mbs_defines.svh
// constants for the serial register-protocol slave: function codes, coil map,
// frame layout and checksum parameters; included by the slave and by the bench
`ifndef MBS_DEFINES_SVH
`define MBS_DEFINES_SVH

`define MBS_FC_RD_HOLD 8'h03
`define MBS_FC_WR_COIL 8'h05
`define MBS_FC_WR_REG 8'h06
`define MBS_FC_WR_COILS 8'h0f
`define MBS_FC_WR_REGS 8'h10
`define MBS_BCAST_ADDR 8'h00
`define MBS_COIL_ON 16'hff00
`define MBS_COIL_OFF 16'h0000
`define MBS_COIL_PARAM_WR 16'h0040
`define MBS_COIL_SPEED_LO 16'h0010
`define MBS_COIL_SPEED_HI 16'h001f
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001
`define MBS_HDR_LEN 4'h7
`define MBS_ECHO_LEN 9'h006
`define MBS_MIN_LEN 9'h004
`define MBS_PARAM_SCALE 16'h000a

`endif

// ### mbs_pkg.sv
// types shared by the slave command handler
// assumes mbs_defines.svh is on the include path
`default_nettype none
package mbs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CHECK = 4'h1,
    ST_MC_RD = 4'h2,
    ST_MC_AP = 4'h3,
    ST_MR_RD0 = 4'h4,
    ST_MR_RD1 = 4'h5,
    ST_MR_WR = 4'h6,
    ST_DONE = 4'h7,
    ST_TX_FETCH = 4'h8,
    ST_TX_LOAD = 4'h9,
    ST_TX_SEND = 4'ha
  } mbs_state_t;
endpackage
`default_nettype wire

// ### mbs_mem.sv
// simple dual-port memory, one write port, one registered read port
// assumes a single clock shared with the caller
`timescale 1ns/10ps
`default_nettype none
module mbs_mem #(
  parameter int W = 8,
  parameter int AW = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [W-1:0] wData,
  input wire logic re,
  input wire logic [AW-1:0] rAddr,
  output logic [W-1:0] rData_q
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // storage array carries no reset so it can map onto block ram
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  // read data registered, valid the cycle after re
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rData_q <= '0;
    end else if (re) begin
      rData_q <= mem[rAddr];
    end
  end
endmodule
`default_nettype wire

// ### mbs_slave.sv
// command handler for a serial register-protocol slave: frame check, coil and
// holding register writes, holding register reads, reply generation with crc
// assumes a framer on mclk delivering bytes and an end-of-frame pulse
`timescale 1ns/10ps
`default_nettype none
`include "mbs_defines.svh"
module mbs_slave #(
  parameter int BUF_AW = 8,
  parameter int HOLD_AW = 10
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] slaveAddr,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic rxEnd,
  output logic [7:0] txByte_q,
  output logic txValid_q,
  input wire logic txReady,
  output logic [15:0] speedSetpoint_q,
  output logic paramWrCtl_q,
  output logic paramWrValid_q,
  output logic [15:0] paramWrReg_q,
  output logic [15:0] paramWrNum_q,
  output logic [15:0] paramWrData_q,
  output logic paramWrNv_q
);
  import mbs_pkg::*;

  mbs_state_t state_q;
  logic [7:0] hdr_q [0:6];
  logic [8:0] rxCnt_q;
  logic [15:0] rxCrc_q, txCrc_q, idx_q;
  logic [8:0] txIdx_q;
  logic [7:0] hiByte_q, bufRd, txNext, bufRdAddr;
  logic [15:0] holdRd, addrF, qtyF, coilNum, holdAddr, holdData;
  logic [8:0] expLen, payLen;
  logic bcast, frameOk, lastIdx, coilWe, coilVal, holdWe, holdRe;

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // request fields straight from the captured header
  assign addrF = {hdr_q[2], hdr_q[3]};
  assign qtyF = {hdr_q[4], hdr_q[5]};
  assign bcast = hdr_q[0] == `MBS_BCAST_ADDR;
  assign lastIdx = (idx_q + 16'h0001) == qtyF;

  // expected frame length per code; unknown codes never match
  always_comb begin
    case (hdr_q[1])
      `MBS_FC_RD_HOLD, `MBS_FC_WR_COIL, `MBS_FC_WR_REG: expLen = 9'h008;
      `MBS_FC_WR_COILS, `MBS_FC_WR_REGS: expLen = 9'h009 + {1'b0, hdr_q[6]};
      default: expLen = 9'h000;
    endcase
  end

  // crc over the whole frame including its check bytes leaves zero
  assign frameOk = rxCnt_q >= `MBS_MIN_LEN && rxCrc_q == 16'h0000 &&
    (hdr_q[0] == slaveAddr || bcast) && rxCnt_q == expLen &&
    (qtyF != 16'h0000 || hdr_q[1] == `MBS_FC_WR_COIL || hdr_q[1] == `MBS_FC_WR_REG);

  // reply length: read reply carries 2 bytes per register
  assign payLen = (hdr_q[1] == `MBS_FC_RD_HOLD) ? 9'h003 + {qtyF[7:0], 1'b0} : `MBS_ECHO_LEN;

  // main sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (rxEnd) state_q <= ST_CHECK;
        ST_CHECK: begin
          if (!frameOk) begin
            state_q <= ST_IDLE;
          end else begin
            case (hdr_q[1])
              `MBS_FC_WR_COILS: state_q <= ST_MC_RD;
              `MBS_FC_WR_REGS: state_q <= ST_MR_RD0;
              `MBS_FC_RD_HOLD: state_q <= bcast ? ST_IDLE : ST_TX_FETCH;
              default: state_q <= ST_DONE;
            endcase
          end
        end
        ST_MC_RD: state_q <= ST_MC_AP;
        ST_MC_AP: state_q <= lastIdx ? ST_DONE : ST_MC_RD;
        ST_MR_RD0: state_q <= ST_MR_RD1;
        ST_MR_RD1: state_q <= ST_MR_WR;
        ST_MR_WR: state_q <= lastIdx ? ST_DONE : ST_MR_RD0;
        ST_DONE: state_q <= bcast ? ST_IDLE : ST_TX_FETCH;
        ST_TX_FETCH: state_q <= ST_TX_LOAD;
        ST_TX_LOAD: state_q <= ST_TX_SEND;
        ST_TX_SEND: begin
          if (txReady) state_q <= (txIdx_q == payLen + 9'h001) ? ST_IDLE : ST_TX_FETCH;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // frame reception; bytes arriving while busy are ignored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxCnt_q <= '0;
      rxCrc_q <= `MBS_CRC_INIT;
      for (int i = 0; i < 7; i++) hdr_q[i] <= 8'h00;
    end else if (state_q == ST_CHECK) begin
      rxCnt_q <= '0;
      rxCrc_q <= `MBS_CRC_INIT;
    end else if (state_q == ST_IDLE && rxValid) begin
      rxCrc_q <= crcByte(rxCrc_q, rxByte);
      if (rxCnt_q != 9'h1ff) rxCnt_q <= rxCnt_q + 9'h001;
      if (rxCnt_q < {5'h00, `MBS_HDR_LEN}) hdr_q[rxCnt_q[2:0]] <= rxByte;
    end
  end

  // loop index for multi-item writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= '0;
      hiByte_q <= '0;
    end else if (state_q == ST_CHECK) begin
      idx_q <= '0;
    end else if (state_q == ST_MC_AP || state_q == ST_MR_WR) begin
      idx_q <= idx_q + 16'h0001;
    end else if (state_q == ST_MR_RD1) begin
      hiByte_q <= bufRd;
    end
  end

  // buffer read pointer: data bytes start after the 7 header bytes
  always_comb begin
    case (state_q)
      ST_MC_RD: bufRdAddr = 8'(idx_q >> 3) + 8'h07;
      ST_MR_RD0: bufRdAddr = 8'({idx_q[6:0], 1'b0}) + 8'h07;
      ST_MR_RD1: bufRdAddr = 8'({idx_q[6:0], 1'b0}) + 8'h08;
      default: bufRdAddr = 8'h00;
    endcase
  end

  mbs_mem #(.W(8), .AW(BUF_AW)) uBuf (
    .mclk(mclk),
    .arst_n(arst_n),
    .we(state_q == ST_IDLE && rxValid && rxCnt_q < 9'(1 << BUF_AW)),
    .wAddr(rxCnt_q[BUF_AW-1:0]),
    .wData(rxByte),
    .re(1'b1),
    .rAddr(BUF_AW'(bufRdAddr)),
    .rData_q(bufRd)
  );

  // coil write decode, shared by single and multi coil writes
  always_comb begin
    coilWe = 1'b0;
    coilVal = 1'b0;
    coilNum = addrF;
    if (state_q == ST_CHECK && frameOk && hdr_q[1] == `MBS_FC_WR_COIL) begin
      coilWe = qtyF == `MBS_COIL_ON || qtyF == `MBS_COIL_OFF;
      coilVal = qtyF == `MBS_COIL_ON;
    end else if (state_q == ST_MC_AP) begin
      coilWe = 1'b1;
      coilNum = addrF + idx_q;
      coilVal = bufRd[idx_q[2:0]];
    end
  end

  // coil targets; other coil numbers are accepted but have no effect here
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      speedSetpoint_q <= '0;
      paramWrCtl_q <= 1'b0;
    end else if (coilWe) begin
      if (coilNum == `MBS_COIL_PARAM_WR) paramWrCtl_q <= coilVal;
      if (coilNum >= `MBS_COIL_SPEED_LO && coilNum <= `MBS_COIL_SPEED_HI) begin
        speedSetpoint_q[coilNum[3:0]] <= coilVal;
      end
    end
  end

  // holding register write decode
  always_comb begin
    holdWe = 1'b0;
    holdAddr = addrF;
    holdData = qtyF;
    if (state_q == ST_CHECK && frameOk && hdr_q[1] == `MBS_FC_WR_REG) begin
      holdWe = 1'b1;
    end else if (state_q == ST_MR_WR) begin
      holdWe = 1'b1;
      holdAddr = addrF + idx_q;
      holdData = {hiByte_q, bufRd};
    end
    if (state_q == ST_TX_FETCH) begin
      holdAddr = addrF + 16'((txIdx_q - 9'h003) >> 1);
    end
  end
  assign holdRe = state_q == ST_TX_FETCH;

  // upper address bits beyond HOLD_AW alias onto the local copy
  mbs_mem #(.W(16), .AW(HOLD_AW)) uHold (
    .mclk(mclk),
    .arst_n(arst_n),
    .we(holdWe),
    .wAddr(holdAddr[HOLD_AW-1:0]),
    .wData(holdData),
    .re(holdRe),
    .rAddr(holdAddr[HOLD_AW-1:0]),
    .rData_q(holdRd)
  );

  // parameter write strobe toward the parameter store
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      paramWrValid_q <= 1'b0;
      paramWrReg_q <= '0;
      paramWrNum_q <= '0;
      paramWrData_q <= '0;
      paramWrNv_q <= 1'b0;
    end else begin
      paramWrValid_q <= holdWe;
      if (holdWe) begin
        paramWrReg_q <= holdAddr;
        // one extra bit so the top register does not wrap to parameter zero
        paramWrNum_q <= 16'((17'(holdAddr) + 17'h00001) / 17'(`MBS_PARAM_SCALE));
        paramWrData_q <= holdData;
        paramWrNv_q <= paramWrCtl_q;
      end
    end
  end

  // reply byte selection: echo header, or read reply with data
  always_comb begin
    txNext = 8'h00;
    if (txIdx_q == payLen) begin
      txNext = txCrc_q[7:0];
    end else if (txIdx_q > payLen) begin
      txNext = txCrc_q[15:8];
    end else if (hdr_q[1] == `MBS_FC_RD_HOLD && txIdx_q >= 9'h002) begin
      if (txIdx_q == 9'h002) txNext = {qtyF[6:0], 1'b0};
      else txNext = txIdx_q[0] ? holdRd[15:8] : holdRd[7:0];
    end else begin
      txNext = hdr_q[txIdx_q[2:0]];
    end
  end

  // reply transmitter; txCrc covers payload bytes only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txIdx_q <= '0;
      txCrc_q <= `MBS_CRC_INIT;
      txByte_q <= 8'h00;
      txValid_q <= 1'b0;
    end else if (state_q == ST_CHECK) begin
      txIdx_q <= '0;
      txCrc_q <= `MBS_CRC_INIT;
    end else if (state_q == ST_TX_LOAD) begin
      txByte_q <= txNext;
      txValid_q <= 1'b1;
    end else if (state_q == ST_TX_SEND && txReady) begin
      txValid_q <= 1'b0;
      txIdx_q <= txIdx_q + 9'h001;
      if (txIdx_q < payLen) txCrc_q <= crcByte(txCrc_q, txByte_q);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_bcast_silent;
    state_q != ST_IDLE && bcast |-> !txValid_q;
  endproperty
  a_bcast_silent: assert property (p_bcast_silent) else $error("reply to broadcast");

  property p_drop_bad;
    state_q == ST_CHECK && !frameOk |=> state_q == ST_IDLE ##1 !txValid_q;
  endproperty
  a_drop_bad: assert property (p_drop_bad) else $error("bad frame not dropped");

  property p_coil_on;
    state_q == ST_CHECK && frameOk && hdr_q[1] == `MBS_FC_WR_COIL &&
      addrF == `MBS_COIL_PARAM_WR && qtyF == `MBS_COIL_ON |=> paramWrCtl_q;
  endproperty
  a_coil_on: assert property (p_coil_on) else $error("param coil not set");

  property p_nv_follow;
    paramWrValid_q |-> paramWrNv_q == $past(paramWrCtl_q);
  endproperty
  a_nv_follow: assert property (p_nv_follow) else $error("nv flag mismatch");

  property p_speed_bit;
    state_q == ST_MC_AP && coilNum >= `MBS_COIL_SPEED_LO && coilNum <= `MBS_COIL_SPEED_HI
      |=> speedSetpoint_q[$past(coilNum[3:0])] == $past(coilVal);
  endproperty
  a_speed_bit: assert property (p_speed_bit) else $error("speed bit not updated");

  property p_byte_count;
    state_q == ST_TX_LOAD && hdr_q[1] == `MBS_FC_RD_HOLD && txIdx_q == 9'h002
      |=> txValid_q && txByte_q == {qtyF[6:0], 1'b0};
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("wrong byte count");

  property p_param_num;
    paramWrValid_q |-> 17'(paramWrNum_q) * 17'd10 <= 17'(paramWrReg_q) + 17'd1 &&
      17'(paramWrNum_q) * 17'd10 + 17'd10 > 17'(paramWrReg_q) + 17'd1;
  endproperty
  a_param_num: assert property (p_param_num) else $error("parameter number wrong");

  property p_echo;
    txValid_q && txIdx_q < 9'h006 && hdr_q[1] != `MBS_FC_RD_HOLD
      |-> txByte_q == hdr_q[txIdx_q[2:0]];
  endproperty
  a_echo: assert property (p_echo) else $error("echo byte mismatch");

  property p_short_reply;
    txValid_q && (hdr_q[1] == `MBS_FC_WR_COILS || hdr_q[1] == `MBS_FC_WR_REGS)
      |-> txIdx_q < 9'h008;
  endproperty
  a_short_reply: assert property (p_short_reply) else $error("reply too long");

  c_read: cover property (state_q == ST_TX_SEND && txReady && hdr_q[1] == `MBS_FC_RD_HOLD);
  c_coils: cover property (state_q == ST_MC_AP && lastIdx);
  c_regs: cover property (state_q == ST_MR_WR && lastIdx && !bcast);
  c_bcast: cover property (state_q == ST_DONE && bcast);
endmodule
`default_nettype wire

// ### mbs_master_model.sv
// far-side master: sends request frames, collects reply bytes
// assumes the bench calls send() and reads replyQ by hierarchy
`timescale 1ns/10ps
`default_nettype none
module mbs_master_model (
  input wire logic mclk,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic rxEnd,
  input wire logic [7:0] txByte_q,
  input wire logic txValid_q,
  output logic txReady
);
  logic [7:0] replyQ[$];
  logic slowMode;
  initial begin
    rxByte = 8'h5a;
    rxValid = 1'b0;
    rxEnd = 1'b0;
    txReady = 1'b0;
    slowMode = 1'b0;
  end
  // check field over a byte queue
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // whole frame; bad flips one check bit so the slave must drop it
  task automatic send(input logic [7:0] body[$], input logic bad);
    logic [15:0] c;
    c = crc16(body) ^ {15'h0000, bad};
    body.push_back(c[7:0]);
    body.push_back(c[15:8]);
    replyQ.delete();
    foreach (body[i]) begin
      @(posedge mclk);
      rxByte <= body[i];
      rxValid <= 1'b1;
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    rxEnd <= 1'b1;
    rxByte <= ~rxByte; // no stale byte left on the idle line
    @(posedge mclk);
    rxEnd <= 1'b0;
  endtask
  // take reply bytes; slow mode stalls at random
  always @(posedge mclk) begin
    if (txValid_q && txReady) begin
      replyQ.push_back(txByte_q);
    end
    txReady <= slowMode ? 1'($urandom_range(1, 0)) : 1'b1;
  end
endmodule
`default_nettype wire

// ### tb.sv
// bench for the slave command handler with a reference model
// assumes mbs_master_model on the far side
`timescale 1ns/10ps
`default_nettype none
`include "mbs_defines.svh"
module tb;
  logic mclk, arst_n, rxValid, rxEnd, txValid_q, txReady, expCtl;
  logic paramWrCtl_q, paramWrValid_q, paramWrNv_q;
  logic [7:0] slaveAddr, rxByte, txByte_q;
  logic [15:0] speedSetpoint_q, paramWrReg_q, paramWrNum_q, paramWrData_q, expSpeed, a;
  logic [15:0] holdMem[int];
  logic [48:0] expWr[$];
  logic [7:0] q[$];
  logic [7:0] none[$];
  int n_errors, checks_done;

  mbs_slave u_dut (.mclk(mclk), .arst_n(arst_n), .slaveAddr(slaveAddr), .rxByte(rxByte),
    .rxValid(rxValid), .rxEnd(rxEnd), .txByte_q(txByte_q), .txValid_q(txValid_q),
    .txReady(txReady), .speedSetpoint_q(speedSetpoint_q), .paramWrCtl_q(paramWrCtl_q),
    .paramWrValid_q(paramWrValid_q), .paramWrReg_q(paramWrReg_q),
    .paramWrNum_q(paramWrNum_q), .paramWrData_q(paramWrData_q), .paramWrNv_q(paramWrNv_q));
  mbs_master_model u_master (.mclk(mclk), .rxByte(rxByte), .rxValid(rxValid),
    .rxEnd(rxEnd), .txByte_q(txByte_q), .txValid_q(txValid_q), .txReady(txReady));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [48:0] seen, input logic [48:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // each strobe must match the oldest expected write
  always @(posedge mclk) begin
    if (arst_n && paramWrValid_q) begin
      if (expWr.size() == 0) check(49'h1, 49'h0);
      else check({paramWrNv_q, paramWrReg_q, paramWrNum_q, paramWrData_q}, expWr.pop_front());
    end
  end

  // one frame out, reply and side outputs compared
  task automatic transact(input logic [7:0] req[$], input logic [7:0] rep[$], input logic bad);
    logic [15:0] c;
    int t;
    c = u_master.crc16(rep);
    if (rep.size() > 0) rep = {rep, c[7:0], c[15:8]};
    u_master.send(req, bad);
    t = 0;
    while (u_master.replyQ.size() < rep.size() && t < 4000) begin
      @(posedge mclk);
      t++;
    end
    // a short reply after the bound is a hang: report and close the run
    if (u_master.replyQ.size() < rep.size()) begin
      check(49'h1, 49'h0);
      stop_test();
    end else begin
      repeat (80) @(posedge mclk);
      check(49'(u_master.replyQ.size()), 49'(rep.size()));
      foreach (rep[i]) check(49'(u_master.replyQ[i]), 49'(rep[i]));
      check(49'({paramWrCtl_q, speedSetpoint_q}), 49'({expCtl, expSpeed}));
      check(49'(expWr.size()), 49'h0);
    end
  endtask

  task automatic setCoil(input logic [15:0] c, input logic v);
    if (c == `MBS_COIL_PARAM_WR) expCtl = v;
    if (c >= `MBS_COIL_SPEED_LO && c <= `MBS_COIL_SPEED_HI) expSpeed[c[3:0]] = v;
  endtask

  task automatic wrCoil(input logic [7:0] sa, input logic [15:0] c, input logic [15:0] v);
    logic [7:0] r[$];
    r = {sa, `MBS_FC_WR_COIL, c[15:8], c[7:0], v[15:8], v[7:0]};
    if (v == `MBS_COIL_ON || v == `MBS_COIL_OFF) setCoil(c, v[15]);
    if (sa == `MBS_BCAST_ADDR) transact(r, none, 1'b0);
    else transact(r, r, 1'b0);
  endtask

  // packed coils: first coil in bit 0, unused bits zero
  task automatic wrCoils(input logic [15:0] c, input logic [15:0] n, input logic [15:0] d);
    logic [7:0] r[$];
    logic [7:0] f[$];
    d = d & 16'((17'h1 << n) - 17'h1);
    for (int k = 0; k < n; k++) setCoil(c + 16'(k), d[k]);
    r = {slaveAddr, `MBS_FC_WR_COILS, c[15:8], c[7:0], n[15:8], n[7:0]};
    f = {r, 8'((n + 16'd7) / 16'd8), d[7:0]};
    if (n > 16'd8) f.push_back(d[15:8]);
    transact(f, r, 1'b0);
  endtask

  task automatic wrRegs(input logic [15:0] s, input logic [15:0] v[$]);
    logic [7:0] r[$];
    logic [7:0] f[$];
    foreach (v[i]) begin
      expWr.push_back({expCtl, s + 16'(i), 16'((s + 16'(i) + 17'h1) / 17'd10), v[i]});
      holdMem[(int'(s) + i) % 1024] = v[i];
    end
    if (v.size() == 1) begin
      r = {slaveAddr, `MBS_FC_WR_REG, s[15:8], s[7:0], v[0][15:8], v[0][7:0]};
      f = r;
    end else begin
      r = {slaveAddr, `MBS_FC_WR_REGS, s[15:8], s[7:0], 8'h00, 8'(v.size())};
      f = {r, 8'(2 * v.size())};
      foreach (v[i]) f = {f, v[i][15:8], v[i][7:0]};
    end
    transact(f, r, 1'b0);
  endtask

  task automatic rdRegs(input logic [15:0] s, input logic [7:0] n);
    logic [7:0] r[$];
    logic [15:0] w;
    logic [7:0] f[$];
    r = {slaveAddr, `MBS_FC_RD_HOLD, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      w = holdMem[(int'(s) + i) % 1024];
      r = {r, w[15:8], w[7:0]};
    end
    f = {slaveAddr, `MBS_FC_RD_HOLD, s[15:8], s[7:0], 8'h00, n};
    transact(f, r, 1'b0);
  endtask

  initial begin
    void'($urandom(32'h11db));
    arst_n = 1'b0;
    slaveAddr = 8'($urandom_range(247, 1));
    expCtl = 1'b0;
    expSpeed = 16'h0000;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    check(49'({paramWrCtl_q, paramWrValid_q, speedSetpoint_q}), 49'h0);
    wrCoil(slaveAddr, `MBS_COIL_PARAM_WR, `MBS_COIL_ON);
    wrCoil(slaveAddr, `MBS_COIL_PARAM_WR, 16'h1234);
    wrRegs(16'd999, '{16'h0001});
    wrCoil(`MBS_BCAST_ADDR, `MBS_COIL_PARAM_WR, `MBS_COIL_OFF);
    u_master.slowMode = 1'b1;
    wrCoils(`MBS_COIL_SPEED_LO, 16'd16, 16'($urandom));
    wrCoils(16'd20, 16'd3, 16'($urandom));
    wrCoil(slaveAddr, `MBS_COIL_SPEED_HI, `MBS_COIL_ON);
    for (int i = 0; i < 4; i++) begin
      a = 16'($urandom_range(65000, 0));
      wrRegs(a, '{16'($urandom), 16'($urandom)});
      wrRegs(a + 16'd2, '{16'($urandom)});
      rdRegs(a, 8'd3);
    end
    q = {slaveAddr, `MBS_FC_WR_REG, 8'h00, 8'h05, 8'h12, 8'h34};
    transact(q, none, 1'b1);
    q = {slaveAddr ^ 8'h80, `MBS_FC_WR_COIL, 8'h00, 8'h40, 8'hff, 8'h00};
    transact(q, none, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
